// ### verilog/pmcr_defines.svh
`ifndef PMCR_DEFINES_SVH
`define PMCR_DEFINES_SVH

// ===========================================================================
// Register indices; byte address is four times the index.
// ===========================================================================
`define PMCR_IDX_BASIC_MODE_CONTROL      5'h00
`define PMCR_IDX_BASIC_MODE_STATUS       5'h01
`define PMCR_IDX_ABILITY_ADVERTISEMENT   5'h04
`define PMCR_IDX_PARTNER_ABILITY         5'h05
`define PMCR_IDX_POWER_SAVE_CONTROL      5'h11
`define PMCR_IDX_LINK_STATUS             5'h12
`define PMCR_IDX_REDUCED_INTERFACE_CFG   5'h17
`define PMCR_IDX_CABLE_PAIR_CONTROL      5'h19
`define PMCR_IDX_DEVICE_IDENTIFIER       5'h1a
`define PMCR_IDX_DEVICE_GLOBAL_RESET     5'h1f
`define PMCR_IDX_VENDOR_FIRST            5'h10

// ===========================================================================
// Field positions.
// ===========================================================================
`define PMCR_BMC_RESET_BIT       15
`define PMCR_BMC_SPEED_BIT       13
`define PMCR_BMC_AUTONEG_BIT     12
`define PMCR_BMC_POWER_DOWN_BIT  11
`define PMCR_BMC_RESTART_AN_BIT  9
`define PMCR_BMC_DUPLEX_BIT      8
`define PMCR_PSC_MODE_HI         14
`define PMCR_PSC_MODE_LO         12
`define PMCR_RIC_RMII_BIT        5
`define PMCR_CPC_MODE_HI         15
`define PMCR_CPC_MODE_LO         14
`define PMCR_DGR_RESET_BIT       15

// ===========================================================================
// Reset values and encodings.
// ===========================================================================
`define PMCR_RST_BASIC_MODE_CONTROL     16'h3100
`define PMCR_RST_ABILITY_ADVERTISEMENT  16'h01e1
`define PMCR_RST_POWER_SAVE_CONTROL     16'h0000
`define PMCR_RST_REDUCED_INTERFACE_CFG  16'h0000
`define PMCR_RST_CABLE_PAIR_CONTROL     16'h8000
`define PMCR_SLEEP_ACTIVE               3'h6
`define PMCR_SLEEP_PASSIVE              3'h7
`define PMCR_PAIR_AUTO                  2'h2
`define PMCR_PAIR_AUTO_ALT              2'h3
`define PMCR_PAIR_STRAIGHT              2'h0
`define PMCR_PAIR_CROSS                 2'h1

// ===========================================================================
// Timing.
// ===========================================================================
`define PMCR_CLK_HZ              40000000
`define PMCR_NLP_PERIOD_MS       1400
`define PMCR_NLP_CYCLES          ((`PMCR_CLK_HZ / 1000) * `PMCR_NLP_PERIOD_MS)
`define PMCR_RESET_NS            1000
`define PMCR_CLK_PERIOD_NS       25
`define PMCR_RESET_CYCLES        ((`PMCR_RESET_NS + `PMCR_CLK_PERIOD_NS - 1) / `PMCR_CLK_PERIOD_NS)
`define PMCR_REF_CLK_RMII_MHZ    50

`endif

// ### verilog/pmcr_pkg.sv
`default_nettype none

package pmcr_pkg;

    typedef struct packed {
        logic       autoneg;
        logic       speed_100;
        logic       full_duplex;
        logic [3:0] advert;
        logic [1:0] pair_mode;
        logic       rmii;
        logic       power_down;
        logic       sleep_active;
        logic       sleep_passive;
    } pmcr_ctrl_t;

    typedef struct packed {
        logic       link_up;
        logic       speed_100;
        logic       full_duplex;
        logic       crossover;
        logic       rmii;
        logic [3:0] partner;
    } pmcr_status_t;

    typedef enum logic [2:0] {
        PMCR_PW_RUN   = 3'b001,
        PMCR_PW_DOWN  = 3'b010,
        PMCR_PW_SLEEP = 3'b100
    } pmcr_power_t;

endpackage

`default_nettype wire

// ### verilog/pmcr_sync.sv
`include "pmcr_defines.svh"
`default_nettype none

module pmcr_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;

    // ==========================================================================
    // Three stages; a change counts once stages two and three agree.
    // ==========================================================================
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_ff[i]  <= 1'b0;
                    s2_ff[i]  <= 1'b0;
                    s3_ff[i]  <= 1'b0;
                    out_ff[i] <= 1'b0;
                end else begin
                    s1_ff[i] <= async_in[i];
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    if (s2_ff[i] == s3_ff[i]) begin
                        out_ff[i] <= s3_ff[i];
                    end
                end
            end
        end
    endgenerate

    assign sync_out = out_ff;

endmodule

`default_nettype wire

// ### verilog/pmcr_regs.sv
// Function
// - Bit 12 of basic_mode_control selects auto-negotiated or forced link behaviour; bit 9 only clears itself.
// - In forced mode, speed comes from basic_mode_control bit 13 and duplex from bit 8.
// - When auto-negotiating, the abilities held in ability_advertisement at 0x4 are advertised.
// - Bits 15:14 of cable_pair_control at 0x19 pick straight, crossover or automatic pairing.
// - Bit 5 of reduced_interface_config at 0x17 picks MII or RMII, RMII using a 50 MHz reference.
// - Writing one to basic_mode_control bit 11 puts the device into full power-down.
// - Power_save_control bits 14:12 equal to 110 select active sleep with a link pulse every 1.4 s.
// - Power_save_control bits 14:12 equal to 111 select passive sleep, left when a partner is seen.
// - Bit 15 of basic_mode_control and bit 15 of device_global_reset start a device reset.
// - Standard registers sit at 0x00 to 0x0f and vendor registers at 0x10 to 0x1f.
// - The device latches a management address in 31..0 once after reset release; software can read it back.
// - Link state, speed, duplex, pairing, interface and partner abilities are readable.
`include "pmcr_defines.svh"
`default_nettype none

module pmcr_regs (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [4:0]            mgmt_address,
    input  wire logic                  link_up_pin,
    input  wire logic                  speed_100_pin,
    input  wire logic                  full_duplex_pin,
    input  wire logic                  crossover_pin,
    input  wire logic [3:0]            partner_pin,
    input  wire logic                  partner_detect_pin,
    output pmcr_pkg::pmcr_ctrl_t       ctrl,
    output logic                       core_reset,
    output logic                       core_power_off,
    output logic                       link_pulse,
    output logic                       reference_clock_input_50m
);

    // ==========================================================================
    // Registers.
    // ==========================================================================
    logic [15:0]           bmc_ff;
    logic [15:0]           adv_ff;
    logic [15:0]           psc_ff;
    logic [15:0]           ric_ff;
    logic [15:0]           cpc_ff;
    logic                  dgr_ff;
    logic [4:0]            addr_ff;
    logic                  strap_done_ff;
    logic [15:0]           rst_cnt_ff;
    logic [31:0]           nlp_cnt_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic                  core_reset_ff;
    logic                  power_off_ff;
    logic                  link_pulse_ff;
    logic                  ref50_ff;
    pmcr_pkg::pmcr_ctrl_t  ctrl_ff;
    pmcr_pkg::pmcr_power_t pw_ff;
    pmcr_pkg::pmcr_power_t nxt_pw;
    pmcr_pkg::pmcr_status_t st;

    logic [8:0] status_sync;

    pmcr_sync #(
        .W (9)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({link_up_pin, speed_100_pin, full_duplex_pin, crossover_pin,
                    partner_pin, partner_detect_pin}),
        .sync_out (status_sync)
    );

    wire       partner_seen = status_sync[0];

    // ==========================================================================
    // Status and decode.
    // ==========================================================================
    assign st.link_up     = status_sync[8] & (pw_ff == pmcr_pkg::PMCR_PW_RUN);
    assign st.speed_100   = status_sync[7];
    assign st.full_duplex = status_sync[6];
    assign st.crossover   = status_sync[5];
    assign st.rmii        = ric_ff[`PMCR_RIC_RMII_BIT];
    assign st.partner     = status_sync[4:1];

    wire       setup      = psel & ~penable;
    wire       access     = psel & penable & pready_ff;
    wire       aligned    = (paddr[1:0] == 2'h0) & (paddr[31:7] == 25'h0);
    wire [4:0] idx        = paddr[6:2];
    wire       idx_known  = (idx == `PMCR_IDX_BASIC_MODE_CONTROL) | (idx == `PMCR_IDX_BASIC_MODE_STATUS)
                          | (idx == `PMCR_IDX_ABILITY_ADVERTISEMENT) | (idx == `PMCR_IDX_PARTNER_ABILITY)
                          | (idx == `PMCR_IDX_POWER_SAVE_CONTROL) | (idx == `PMCR_IDX_LINK_STATUS)
                          | (idx == `PMCR_IDX_REDUCED_INTERFACE_CFG) | (idx == `PMCR_IDX_CABLE_PAIR_CONTROL)
                          | (idx == `PMCR_IDX_DEVICE_IDENTIFIER) | (idx == `PMCR_IDX_DEVICE_GLOBAL_RESET);
    wire       hit        = aligned & idx_known;
    wire       wr         = access & pwrite & hit & ~core_reset_ff;
    wire       wr_bmc     = wr & (idx == `PMCR_IDX_BASIC_MODE_CONTROL);
    wire       wr_adv     = wr & (idx == `PMCR_IDX_ABILITY_ADVERTISEMENT);
    wire       wr_psc     = wr & (idx == `PMCR_IDX_POWER_SAVE_CONTROL);
    wire       wr_ric     = wr & (idx == `PMCR_IDX_REDUCED_INTERFACE_CFG);
    wire       wr_cpc     = wr & (idx == `PMCR_IDX_CABLE_PAIR_CONTROL);
    wire       wr_dgr     = wr & (idx == `PMCR_IDX_DEVICE_GLOBAL_RESET);

    // A reset request from either register starts the reset timer.
    wire       reset_req  = (wr_bmc & pwdata[`PMCR_BMC_RESET_BIT])
                          | (wr_dgr & pwdata[`PMCR_DGR_RESET_BIT]);
    wire       reset_done = core_reset_ff & (rst_cnt_ff == 16'h0001);

    wire [2:0] sleep_mode = psc_ff[`PMCR_PSC_MODE_HI:`PMCR_PSC_MODE_LO];
    wire       sleep_act  = (sleep_mode == `PMCR_SLEEP_ACTIVE);
    wire       sleep_pas  = (sleep_mode == `PMCR_SLEEP_PASSIVE);
    wire       want_down  = bmc_ff[`PMCR_BMC_POWER_DOWN_BIT];

    wire [1:0] pair_sel   = cpc_ff[`PMCR_CPC_MODE_HI:`PMCR_CPC_MODE_LO];
    wire       autoneg    = bmc_ff[`PMCR_BMC_AUTONEG_BIT];

    wire [15:0] rd_word =
        (idx == `PMCR_IDX_BASIC_MODE_CONTROL)    ? bmc_ff :
        (idx == `PMCR_IDX_BASIC_MODE_STATUS)     ? {10'h000, st.full_duplex, st.speed_100,
                                                    3'h0, st.link_up} :
        (idx == `PMCR_IDX_ABILITY_ADVERTISEMENT) ? adv_ff :
        (idx == `PMCR_IDX_PARTNER_ABILITY)       ? {7'h00, st.partner, 5'h01} :
        (idx == `PMCR_IDX_POWER_SAVE_CONTROL)    ? psc_ff :
        (idx == `PMCR_IDX_LINK_STATUS)           ? {9'h000, st.rmii, st.crossover, st.full_duplex,
                                                    st.speed_100, pw_ff[2], pw_ff[1], st.link_up} :
        (idx == `PMCR_IDX_REDUCED_INTERFACE_CFG) ? ric_ff :
        (idx == `PMCR_IDX_CABLE_PAIR_CONTROL)    ? cpc_ff :
        (idx == `PMCR_IDX_DEVICE_IDENTIFIER)     ? {11'h000, addr_ff} :
                                                   {dgr_ff, 15'h0000};

    // ==========================================================================
    // Power state machine.
    // ==========================================================================
    always_comb begin
        nxt_pw = pw_ff;
        unique case (pw_ff)
            pmcr_pkg::PMCR_PW_RUN: begin
                if (want_down) begin
                    nxt_pw = pmcr_pkg::PMCR_PW_DOWN;
                end else if ((sleep_act | sleep_pas) & !partner_seen) begin
                    nxt_pw = pmcr_pkg::PMCR_PW_SLEEP;
                end
            end
            pmcr_pkg::PMCR_PW_DOWN: begin
                if (!want_down) begin
                    nxt_pw = pmcr_pkg::PMCR_PW_RUN;
                end
            end
            pmcr_pkg::PMCR_PW_SLEEP: begin
                if (want_down) begin
                    nxt_pw = pmcr_pkg::PMCR_PW_DOWN;
                end else if (partner_seen | !(sleep_act | sleep_pas)) begin
                    nxt_pw = pmcr_pkg::PMCR_PW_RUN;
                end
            end
            default: begin
                nxt_pw = pmcr_pkg::PMCR_PW_RUN;
            end
        endcase
    end

    // ==========================================================================
    // Management address strap, caught once after reset release.
    // ==========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff       <= 5'h00;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            addr_ff       <= mgmt_address;
            strap_done_ff <= 1'b1;
        end
    end

    // ==========================================================================
    // Control registers; a reset request returns them to defaults, with basic_mode_control bit 15 left set.
    // ==========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bmc_ff <= `PMCR_RST_BASIC_MODE_CONTROL;
            adv_ff <= `PMCR_RST_ABILITY_ADVERTISEMENT;
            psc_ff <= `PMCR_RST_POWER_SAVE_CONTROL;
            ric_ff <= `PMCR_RST_REDUCED_INTERFACE_CFG;
            cpc_ff <= `PMCR_RST_CABLE_PAIR_CONTROL;
        end else if (reset_req) begin
            bmc_ff <= `PMCR_RST_BASIC_MODE_CONTROL | 16'h8000;
            adv_ff <= `PMCR_RST_ABILITY_ADVERTISEMENT;
            psc_ff <= `PMCR_RST_POWER_SAVE_CONTROL;
            ric_ff <= `PMCR_RST_REDUCED_INTERFACE_CFG;
            cpc_ff <= `PMCR_RST_CABLE_PAIR_CONTROL;
        end else begin
            if (wr_bmc) begin
                bmc_ff <= pwdata[15:0] & 16'h7fff;
            end else if (reset_done) begin
                bmc_ff[`PMCR_BMC_RESET_BIT] <= 1'b0;
            end else if (bmc_ff[`PMCR_BMC_RESTART_AN_BIT]) begin
                bmc_ff[`PMCR_BMC_RESTART_AN_BIT] <= 1'b0;
            end
            if (wr_adv) begin
                adv_ff <= pwdata[15:0];
            end
            if (wr_psc) begin
                psc_ff <= pwdata[15:0];
            end
            if (wr_ric) begin
                ric_ff <= pwdata[15:0];
            end
            if (wr_cpc) begin
                cpc_ff <= pwdata[15:0];
            end
        end
    end

    // ==========================================================================
    // Reset timer; request wins over completion.
    // ==========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dgr_ff        <= 1'b0;
            core_reset_ff <= 1'b0;
            rst_cnt_ff    <= 16'h0000;
        end else if (reset_req) begin
            dgr_ff        <= wr_dgr & pwdata[`PMCR_DGR_RESET_BIT];
            core_reset_ff <= 1'b1;
            rst_cnt_ff    <= 16'(`PMCR_RESET_CYCLES);
        end else if (reset_done) begin
            dgr_ff        <= 1'b0;
            core_reset_ff <= 1'b0;
            rst_cnt_ff    <= 16'h0000;
        end else if (core_reset_ff) begin
            rst_cnt_ff    <= rst_cnt_ff - 16'h0001;
        end
    end

    // ==========================================================================
    // Power state, link pulse timer and derived control.
    // ==========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_ff         <= pmcr_pkg::PMCR_PW_RUN;
            nlp_cnt_ff    <= 32'h0000_0000;
            link_pulse_ff <= 1'b0;
        end else begin
            pw_ff <= nxt_pw;
            if (pw_ff == pmcr_pkg::PMCR_PW_SLEEP && sleep_act &&
                nlp_cnt_ff == 32'(`PMCR_NLP_CYCLES - 1)) begin
                nlp_cnt_ff    <= 32'h0000_0000;
                link_pulse_ff <= 1'b1;
            end else begin
                nlp_cnt_ff    <= (pw_ff == pmcr_pkg::PMCR_PW_SLEEP && sleep_act) ?
                                 nlp_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
                link_pulse_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff      <= '0;
            power_off_ff <= 1'b0;
            ref50_ff     <= 1'b0;
        end else begin
            ctrl_ff.autoneg       <= autoneg;
            ctrl_ff.speed_100     <= autoneg ? st.speed_100 : bmc_ff[`PMCR_BMC_SPEED_BIT];
            ctrl_ff.full_duplex   <= autoneg ? st.full_duplex : bmc_ff[`PMCR_BMC_DUPLEX_BIT];
            ctrl_ff.advert        <= autoneg ? adv_ff[8:5] : 4'h0;
            ctrl_ff.pair_mode     <= (pair_sel == `PMCR_PAIR_AUTO_ALT) ? `PMCR_PAIR_AUTO : pair_sel;
            ctrl_ff.rmii          <= ric_ff[`PMCR_RIC_RMII_BIT];
            ctrl_ff.power_down    <= (pw_ff == pmcr_pkg::PMCR_PW_DOWN);
            ctrl_ff.sleep_active  <= (pw_ff == pmcr_pkg::PMCR_PW_SLEEP) & sleep_act;
            ctrl_ff.sleep_passive <= (pw_ff == pmcr_pkg::PMCR_PW_SLEEP) & sleep_pas;
            power_off_ff          <= (pw_ff != pmcr_pkg::PMCR_PW_RUN);
            ref50_ff              <= ric_ff[`PMCR_RIC_RMII_BIT];
        end
    end

    // ==========================================================================
    // APB slave: no wait states, error on unmapped or misaligned address.
    // ==========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~hit;
            prdata_ff  <= (setup & hit & ~pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    assign prdata                    = prdata_ff;
    assign pready                    = pready_ff;
    assign pslverr                   = pslverr_ff;
    assign ctrl                      = ctrl_ff;
    assign core_reset                = core_reset_ff;
    assign core_power_off            = power_off_ff;
    assign link_pulse                = link_pulse_ff;
    assign reference_clock_input_50m = ref50_ff;

endmodule

`default_nettype wire

// ### testbench/pmcr_properties.sv
`default_nettype none
// ==========================================================
// Timing and field relations at the register bank ports.
module pmcr_checker (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [4:0]           mgmt_address,
    input wire pmcr_pkg::pmcr_ctrl_t ctrl,
    input wire logic                 core_reset,
    input wire logic                 core_power_off,
    input wire logic                 link_pulse,
    input wire logic                 reference_clock_input_50m
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready) else $error("no answer");
    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("long pready");
    AST_ERR_UNMAPPED: assert property (pready && (paddr >= 32'h80 || paddr[1:0] != 2'h0)
        |-> pslverr && prdata == 32'h0) else $error("unmapped accepted");
    AST_STRAP_READ: assert property (pready && !pwrite && paddr == 32'h68
        |-> prdata == {27'h0, mgmt_address}) else $error("bad identifier");
    AST_FORCED_NO_ADVERT: assert property (!ctrl.autoneg |-> ctrl.advert == 4'h0) else $error("advert");
    AST_RMII_CLOCK: assert property (ctrl.rmii |-> ##[0:1] reference_clock_input_50m) else $error("ref");
    AST_POWER_DOWN: assert property (ctrl.power_down |-> ##[0:2] core_power_off) else $error("down");
    AST_RESET_WRITE: assert property (pready && pwrite && pwdata[15] && (paddr == 32'h7c || paddr == 32'h0)
        |-> ##[1:2] core_reset) else $error("no reset");
    AST_PULSE_IN_SLEEP: assert property (link_pulse |-> ctrl.sleep_active) else $error("pulse");
    AST_RESET_ENDS: assert property ($rose(core_reset) |-> ##[40:48] !core_reset) else $error("stuck");
endmodule

bind pmcr_regs pmcr_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mgmt_address, .ctrl, .core_reset, .core_power_off, .link_pulse,
    .reference_clock_input_50m);
`default_nettype wire

// ### testbench/pmcr_host.sv
`default_nettype none
// ==========================================================
// APB master in place of the management host.
module pmcr_host (
    input  wire logic   pclk,
    input  wire logic   pready,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int timeouts = 0;
    initial {psel, penable, pwrite, paddr, pwdata} = 67'h0;
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (k >= 50) timeouts++;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### testbench/phy_mode_control_registers_tb.sv
`default_nettype none
// ==========================================================
// Self-checking bench for the mode control register bank.
module phy_mode_control_registers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, ref50, core_reset;
    logic                 link_up_pin, speed_100_pin, full_duplex_pin, crossover_pin, partner_detect_pin;
    logic                 core_power_off, link_pulse;
    logic [31:0]          paddr, pwdata, prdata;
    logic [4:0]           mgmt_address;
    logic [3:0]           partner_pin;
    pmcr_pkg::pmcr_ctrl_t ctrl, exp_ctrl;
    logic [32:0]          expq[$];
    int                   errors = 0, samples_checked = 0, seed = 31187, n;
    logic [31:0]          atab[5] = '{32'h0, 32'h10, 32'h44, 32'h5c, 32'h64};
    logic [15:0]          rtab[5] = '{16'h3100, 16'h01e1, 16'h0, 16'h0, 16'h8000};

    pmcr_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mgmt_address, .link_up_pin, .speed_100_pin, .full_duplex_pin, .crossover_pin, .partner_pin,
        .partner_detect_pin, .ctrl, .core_reset, .core_power_off, .link_pulse, .reference_clock_input_50m(ref50));
    pmcr_host host (.pclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);

    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: bus %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        expq.push_back(33'h0);
        host.xfer(1'h1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [32:0] e);
        expq.push_back(e);
        host.xfer(1'h0, a, 32'h0);
    endtask
    task automatic wrap_up();
        errors += host.timeouts;
        $display("Checked %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic await(ref logic s, input logic v);
        int k;
        for (k = 0; s !== v && k < 200; k++) @(posedge pclk);
        if (k >= 200) begin
            errors++;
            wrap_up();
        end
    endtask
    // The monitor pairs each completed transfer with the oldest expectation.
    always @(posedge pclk)
        if (psel && penable && pready === 1'h1 && expq.size() > 0)
            chk_bus({pslverr, prdata}, expq.pop_front());
    initial begin
        tick(20000);
        errors++;
        wrap_up();
    end
    initial begin
        presetn = 1'h0;
        partner_detect_pin = 1'h0;
        {mgmt_address, partner_pin, link_up_pin, speed_100_pin, full_duplex_pin, crossover_pin} = 13'($random(seed));
        tick(5);
        presetn <= 1'h1;
        tick(2);
        // Speed and duplex follow the link status, not yet through the synchroniser here.
        exp_ctrl = '{1'h1, 1'h0, 1'h0, 4'hf, 2'h2, 1'h0, 1'h0, 1'h0, 1'h0};
        chk_out(32'(ctrl), 32'(exp_ctrl));
        for (int i = 0; i < 5; i++) rd(atab[i], {17'h0, rtab[i]});
        wr(32'h68, 32'hffff);
        rd(32'h68, {28'h0, mgmt_address});
        rd(32'h14, {24'h0, partner_pin, 5'h1});
        rd(32'h48, {27'h0, crossover_pin, full_duplex_pin, speed_100_pin, 2'h0, link_up_pin});
        rd(32'h80, {1'h1, 32'h0});
        rd(32'h2, {1'h1, 32'h0});
        for (int i = 0; i < 4; i++) begin
            wr(32'h0, {18'h0, i[1], 4'h0, i[0], 8'h0});
            tick(3);
            exp_ctrl = '{1'h0, i[1], i[0], 4'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h0};
            chk_out(32'(ctrl), 32'(exp_ctrl));
        end
        n = $random(seed);
        wr(32'h10, {23'h0, n[3:0], 5'h1});
        wr(32'h0, 32'h3100);
        tick(3);
        chk_out(32'(ctrl.advert), 32'(n[3:0]));
        for (int i = 0; i < 4; i++) begin
            wr(32'h64, {16'h0, i[1:0], 14'h0});
            tick(3);
            chk_out(32'(ctrl.pair_mode), 32'((i == 3) ? 2 : i));
        end
        wr(32'h5c, 32'h20);
        tick(3);
        chk_out(32'({ctrl.rmii, ref50}), 32'h3);
        wr(32'h0, 32'h3900);
        tick(3);
        chk_out(32'({ctrl.power_down, core_power_off}), 32'h3);
        wr(32'h0, 32'h3100);
        wr(32'h44, 32'h6000);
        tick(3);
        chk_out(32'({ctrl.sleep_active, core_power_off}), 32'h3);
        wr(32'h44, 32'h7000);
        tick(3);
        chk_out(32'({ctrl.sleep_passive, core_power_off}), 32'h3);
        partner_detect_pin <= 1'h1;
        await(core_power_off, 1'h0);
        wr(32'h44, 32'h0);
        partner_detect_pin <= 1'h0;
        for (int i = 0; i < 2; i++) begin
            wr(i ? 32'h0 : 32'h7c, 32'h8000);
            tick(1);
            chk_out(32'(core_reset), 32'h1);
            wr(32'h5c, 32'h20);
            rd(i ? 32'h0 : 32'h7c, i ? 33'hb100 : 33'h8000);
            await(core_reset, 1'h0);
            rd(i ? 32'h0 : 32'h7c, i ? 33'h3100 : 33'h0);
            rd(32'h5c, 33'h0);
        end
        chk_out(32'(expq.size()), 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
